// ===== shared/hp_routing_defines.vh
// Register indices, field positions, reset values and bus codes
`ifndef HP_ROUTING_DEFINES_VH
`define HP_ROUTING_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_RDAC_LCOM    7'h39
`define IDX_LCOM_CTRL    7'h3A
`define IDX_RSVD_A       7'h3B
`define IDX_LGAIN_ROUT   7'h3C
`define IDX_LDAC_ROUT    7'h3D
`define IDX_RSVD_B       7'h3E
`define IDX_RGAIN_ROUT   7'h3F
`define IDX_RDAC_ROUT    7'h40
`define IDX_ROUT_CTRL    7'h41

// Routing and volume register fields
`define ROUTE_BIT        7
`define VOL_MSB          6
`define VOL_LSB          0

// Output control register fields
`define LEVEL_MSB        7
`define LEVEL_LSB        4
`define UNMUTE_BIT       3
`define HIZ_BIT          2
`define PENDING_BIT      1
`define POWER_BIT        0
`define LEVEL_MAX        4'h9

// Reset values
`define RST_ROUTE_VOL    8'h00
`define RST_CTRL         8'h06
`define RST_RSVD         8'h00

// Avalon response codes
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ===== rtl/gain_pending.v
// Gain settling status flag for one headphone output
`timescale 1ns/10ps
module gain_pending (
  input  wire clk_sys,
  input  wire nrst,
  input  wire ce,
  input  wire new_gain,
  input  wire applied,
  output reg  pending,
  output reg  update
);

  // New gain sets the flag and wins over a same-cycle clear
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pending <= 1'b1;
      update  <= 1'b0;
    end else if (ce) begin
      update <= new_gain;               // Tells the analog side to load
      if (new_gain) begin
        pending <= 1'b1;
      end else if (applied) begin
        pending <= 1'b0;
      end
    end
  end

endmodule // gain_pending

// ===== rtl/hp_routing_regs.v
// Headphone output routing, volume and output control registers
//
// Operation
// - Right DAC to left common route bit
// - Right DAC to left common 7-bit volume
// - Left common level 0 to 9 dB
// - Left common unmute bit, resets muted
// - Left common powered-down drive, resets high-Z
// - Left common gain pending, read-only, resets one
// - Left common full power-up request bit
// - Left gain stage to right out route/volume
// - Left DAC to right out route/volume
// - Right gain stage to right out route/volume
// - Right DAC to right out route/volume
// - Right out level 0 to 9 dB
// - Right out unmute bit, resets muted
// - Right out high-Z select and power-up
// - Right out gain pending, read-only, resets one
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
`include "hp_routing_defines.vh"
module hp_routing_regs (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        ce,
  input  wire [8:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [1:0]  avs_response,
  input  wire        left_com_applied,
  input  wire        right_out_applied,
  output reg         rdac_lcom_route,
  output reg  [6:0]  rdac_lcom_vol,
  output reg  [3:0]  left_com_level,
  output reg         left_com_unmute,
  output reg         left_com_hiz,
  output reg         left_com_power_up,
  output wire        left_com_pending,
  output wire        left_com_update,
  output reg         lgain_rout_route,
  output reg  [6:0]  lgain_rout_vol,
  output reg         ldac_rout_route,
  output reg  [6:0]  ldac_rout_vol,
  output reg         rgain_rout_route,
  output reg  [6:0]  rgain_rout_vol,
  output reg         rdac_rout_route,
  output reg  [6:0]  rdac_rout_vol,
  output reg  [3:0]  right_out_level,
  output reg         right_out_unmute,
  output reg         right_out_hiz,
  output reg         right_out_power_up,
  output wire        right_out_pending,
  output wire        right_out_update
);

  // Level codes above nine are refused and the old level kept
  function level_ok;
    input [3:0] code;
    begin
      level_ok = (code <= `LEVEL_MAX);
    end
  endfunction

  // True when a word index belongs to this register slice
  function idx_mapped;
    input [6:0] idx;
    begin
      case (idx)
        `IDX_RDAC_LCOM, `IDX_LCOM_CTRL, `IDX_RSVD_A,
        `IDX_LGAIN_ROUT, `IDX_LDAC_ROUT, `IDX_RSVD_B,
        `IDX_RGAIN_ROUT, `IDX_RDAC_ROUT, `IDX_ROUT_CTRL:
          idx_mapped = 1'b1;
        default:
          idx_mapped = 1'b0;
      endcase
    end
  endfunction

  reg  [7:0] reserved_a;
  reg  [7:0] reserved_b;
  reg  [7:0] rd_byte;

  wire [6:0] word_idx;
  wire       aligned;
  wire       hit;
  wire       wr_go;
  wire [7:0] wbyte;
  wire       wr_lcom_gain;
  wire       wr_rout_gain;

  // Address decode: word aligned byte addresses only
  assign word_idx = avs_address[8:2];
  assign aligned  = (avs_address[1:0] == 2'h0);
  assign hit      = aligned & idx_mapped(word_idx);

  // A write commits on the edge where waitrequest is seen low
  assign wr_go = ce & avs_write & ~avs_waitrequest & hit &
                 avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // Writes that change a gain for the left common output
  assign wr_lcom_gain = wr_go &
    ((word_idx == `IDX_RDAC_LCOM) |
     ((word_idx == `IDX_LCOM_CTRL) &
      level_ok(wbyte[`LEVEL_MSB:`LEVEL_LSB])));

  // Writes that change a gain for the right output
  assign wr_rout_gain = wr_go &
    ((word_idx == `IDX_LGAIN_ROUT) |
     (word_idx == `IDX_LDAC_ROUT) |
     (word_idx == `IDX_RGAIN_ROUT) |
     (word_idx == `IDX_RDAC_ROUT) |
     ((word_idx == `IDX_ROUT_CTRL) &
      level_ok(wbyte[`LEVEL_MSB:`LEVEL_LSB])));

  // Bus handshake: one wait cycle, then a one-cycle answer
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      avs_response    <= `RESP_OKAY;
    end else if (ce) begin
      if ((avs_read | avs_write) & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_response    <= hit ? `RESP_OKAY : `RESP_SLVERR;
        if (avs_read) begin
          avs_readdata <= {24'h0, rd_byte};
        end
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Read mux; pending bits show live settling state
  always @* begin
    case (word_idx)
      `IDX_RDAC_LCOM:
        rd_byte = {rdac_lcom_route, rdac_lcom_vol};
      `IDX_LCOM_CTRL:
        rd_byte = {left_com_level, left_com_unmute, left_com_hiz,
                   left_com_pending, left_com_power_up};
      `IDX_RSVD_A:
        rd_byte = reserved_a;
      `IDX_LGAIN_ROUT:
        rd_byte = {lgain_rout_route, lgain_rout_vol};
      `IDX_LDAC_ROUT:
        rd_byte = {ldac_rout_route, ldac_rout_vol};
      `IDX_RSVD_B:
        rd_byte = reserved_b;
      `IDX_RGAIN_ROUT:
        rd_byte = {rgain_rout_route, rgain_rout_vol};
      `IDX_RDAC_ROUT:
        rd_byte = {rdac_rout_route, rdac_rout_vol};
      `IDX_ROUT_CTRL:
        rd_byte = {right_out_level, right_out_unmute, right_out_hiz,
                   right_out_pending, right_out_power_up};
      default:
        rd_byte = 8'h00;
    endcase
    if (!aligned) begin
      rd_byte = 8'h00;
    end
  end

  // Right DAC path into the left common output
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdac_lcom_route <= 1'b0;
      rdac_lcom_vol   <= 7'h00;
    end else if (wr_go && word_idx == `IDX_RDAC_LCOM) begin
      rdac_lcom_route <= wbyte[`ROUTE_BIT];
      rdac_lcom_vol   <= wbyte[`VOL_MSB:`VOL_LSB];
    end
  end

  // Left common output control; pending bit is not writable
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      left_com_level    <= 4'h0;
      left_com_unmute   <= 1'b0;
      left_com_hiz      <= 1'b1;
      left_com_power_up <= 1'b0;
    end else if (wr_go && word_idx == `IDX_LCOM_CTRL) begin
      if (level_ok(wbyte[`LEVEL_MSB:`LEVEL_LSB])) begin
        left_com_level <= wbyte[`LEVEL_MSB:`LEVEL_LSB];
      end
      left_com_unmute   <= wbyte[`UNMUTE_BIT];
      left_com_hiz      <= wbyte[`HIZ_BIT];
      left_com_power_up <= wbyte[`POWER_BIT];
    end
  end

  // Reserved storage, kept only so reads return what was there
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reserved_a <= `RST_RSVD;
      reserved_b <= `RST_RSVD;
    end else if (wr_go) begin
      if (word_idx == `IDX_RSVD_A) begin
        reserved_a <= wbyte;
      end
      if (word_idx == `IDX_RSVD_B) begin
        reserved_b <= wbyte;
      end
    end
  end

  // Left input gain stage into the right output
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lgain_rout_route <= 1'b0;
      lgain_rout_vol   <= 7'h00;
    end else if (wr_go && word_idx == `IDX_LGAIN_ROUT) begin
      lgain_rout_route <= wbyte[`ROUTE_BIT];
      lgain_rout_vol   <= wbyte[`VOL_MSB:`VOL_LSB];
    end
  end

  // Left DAC path into the right output
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ldac_rout_route <= 1'b0;
      ldac_rout_vol   <= 7'h00;
    end else if (wr_go && word_idx == `IDX_LDAC_ROUT) begin
      ldac_rout_route <= wbyte[`ROUTE_BIT];
      ldac_rout_vol   <= wbyte[`VOL_MSB:`VOL_LSB];
    end
  end

  // Right input gain stage into the right output
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rgain_rout_route <= 1'b0;
      rgain_rout_vol   <= 7'h00;
    end else if (wr_go && word_idx == `IDX_RGAIN_ROUT) begin
      rgain_rout_route <= wbyte[`ROUTE_BIT];
      rgain_rout_vol   <= wbyte[`VOL_MSB:`VOL_LSB];
    end
  end

  // Right DAC path into the right output
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdac_rout_route <= 1'b0;
      rdac_rout_vol   <= 7'h00;
    end else if (wr_go && word_idx == `IDX_RDAC_ROUT) begin
      rdac_rout_route <= wbyte[`ROUTE_BIT];
      rdac_rout_vol   <= wbyte[`VOL_MSB:`VOL_LSB];
    end
  end

  // Right output control; pending bit is not writable
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      right_out_level    <= 4'h0;
      right_out_unmute   <= 1'b0;
      right_out_hiz      <= 1'b1;
      right_out_power_up <= 1'b0;
    end else if (wr_go && word_idx == `IDX_ROUT_CTRL) begin
      if (level_ok(wbyte[`LEVEL_MSB:`LEVEL_LSB])) begin
        right_out_level <= wbyte[`LEVEL_MSB:`LEVEL_LSB];
      end
      right_out_unmute   <= wbyte[`UNMUTE_BIT];
      right_out_hiz      <= wbyte[`HIZ_BIT];
      right_out_power_up <= wbyte[`POWER_BIT];
    end
  end

  // Settling tracker for the left common output
  gain_pending u_left_com_pending (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .ce       (ce),
    .new_gain (wr_lcom_gain),
    .applied  (left_com_applied),
    .pending  (left_com_pending),
    .update   (left_com_update)
  );

  // Settling tracker for the right output
  gain_pending u_right_out_pending (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .ce       (ce),
    .new_gain (wr_rout_gain),
    .applied  (right_out_applied),
    .pending  (right_out_pending),
    .update   (right_out_update)
  );

endmodule // hp_routing_regs

// ===== tb/hp_routing_monitor.sv
// Concurrent checks on the headphone routing register slice ports
`timescale 1ns/10ps
module hp_routing_monitor (
  input wire        clk_sys,
  input wire        nrst,
  input wire        ce,
  input wire [8:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire        avs_waitrequest,
  input wire [1:0]  avs_response,
  input wire        left_com_applied,
  input wire        rdac_lcom_route,
  input wire [6:0]  rdac_lcom_vol,
  input wire [3:0]  left_com_level,
  input wire        left_com_unmute,
  input wire        left_com_hiz,
  input wire        left_com_power_up,
  input wire        left_com_pending,
  input wire        left_com_update,
  input wire        lgain_rout_route,
  input wire [6:0]  lgain_rout_vol,
  input wire        right_out_applied,
  input wire        right_out_pending,
  input wire        right_out_update
);
  // Accepted byte write, its data and unmapped or unaligned places
  wire       wr_ok = ce && avs_write && !avs_waitrequest &&
                     avs_byteenable[0];
  wire [7:0] d     = avs_writedata[7:0];
  wire       bad   = avs_address[1:0] != 2'h0 ||
                     avs_address < 9'h0E4 || avs_address > 9'h104;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Handshake and register field checks
  chk_wait_answer: assert property ((avs_read || avs_write) && ce &&
    avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
  chk_lcom_route: assert property (
    wr_ok && avs_address == 9'h0E4 |=> {rdac_lcom_route, rdac_lcom_vol}
    == $past(d)) else $error("left common route or volume wrong");
  chk_lcom_level: assert property (
    wr_ok && avs_address == 9'h0E8 |=> left_com_level == ($past(d[7:4])
    > 4'h9 ? $past(left_com_level) : $past(d[7:4])))
    else $error("left common level wrong");
  chk_lcom_bits: assert property (
    wr_ok && avs_address == 9'h0E8 |=> {left_com_unmute, left_com_hiz,
    left_com_power_up} == {$past(d[3]), $past(d[2]), $past(d[0])})
    else $error("left common control bits wrong");
  chk_lcom_pend: assert property (
    wr_ok && avs_address == 9'h0E4 |=> left_com_pending && left_com_update)
    else $error("left common pending not set");
  chk_lcom_clear: assert property (
    left_com_applied && avs_waitrequest && ce |=> !left_com_pending)
    else $error("left common pending not cleared");
  chk_rout_vol: assert property (
    wr_ok && avs_address == 9'h0F0 |=> {lgain_rout_route, lgain_rout_vol}
    == $past(d)) else $error("left gain stage route or volume wrong");
  chk_rout_pend: assert property (
    wr_ok && avs_address == 9'h0F0 |=> right_out_pending &&
    right_out_update) else $error("right out pending not set");
  chk_rout_clear: assert property (
    right_out_applied && avs_waitrequest && ce |=> !right_out_pending)
    else $error("right out pending not cleared");
  chk_bad_addr: assert property (!avs_waitrequest && bad |->
    avs_response == 2'h2) else $error("unmapped access not refused");
  // Main scenarios
  cover property (wr_ok && avs_address == 9'h0E8);
  cover property (left_com_applied && left_com_pending);
  cover property (!avs_waitrequest && bad);
endmodule // hp_routing_monitor

bind hp_routing_regs hp_routing_monitor u_mon (.clk_sys, .nrst, .ce,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .avs_response, .left_com_applied, .rdac_lcom_route,
  .rdac_lcom_vol, .left_com_level, .left_com_unmute, .left_com_hiz,
  .left_com_power_up, .left_com_pending, .left_com_update,
  .lgain_rout_route, .lgain_rout_vol, .right_out_applied,
  .right_out_pending, .right_out_update);

// ===== tb/hp_routing_regs_tb_top.sv
// Self-checking bench for the headphone routing register slice
`timescale 1ns/10ps
module hp_routing_regs_tb_top;
  reg         clk_sys = 1'b0;
  reg         nrst = 1'b0;
  reg         ce = 1'b1;
  reg  [8:0]  avs_address = 9'h000;
  reg         avs_read = 1'b0, avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [3:0]  avs_byteenable = 4'hF;
  reg         left_com_applied = 1'b0, right_out_applied = 1'b0;
  reg  [31:0] rv;
  reg  [1:0]  rs;
  integer     tests_run = 0, miscompares = 0;
  wire [31:0] avs_readdata;
  wire [1:0]  avs_response;
  wire [3:0]  left_com_level, right_out_level;
  wire [6:0]  rdac_lcom_vol, lgain_rout_vol, ldac_rout_vol;
  wire [6:0]  rgain_rout_vol, rdac_rout_vol;
  wire        avs_waitrequest, rdac_lcom_route, lgain_rout_route;
  wire        ldac_rout_route, rgain_rout_route, rdac_rout_route;
  wire        left_com_unmute, left_com_hiz, left_com_power_up;
  wire        left_com_pending, left_com_update, right_out_unmute;
  wire        right_out_hiz, right_out_power_up, right_out_pending;
  wire        right_out_update;

  hp_routing_regs DUT (.clk_sys, .nrst, .ce, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .avs_response, .left_com_applied, .right_out_applied,
    .rdac_lcom_route, .rdac_lcom_vol, .left_com_level, .left_com_unmute,
    .left_com_hiz, .left_com_power_up, .left_com_pending, .left_com_update,
    .lgain_rout_route, .lgain_rout_vol, .ldac_rout_route, .ldac_rout_vol,
    .rgain_rout_route, .rgain_rout_vol, .rdac_rout_route, .rdac_rout_vol,
    .right_out_level, .right_out_unmute, .right_out_hiz,
    .right_out_power_up, .right_out_pending, .right_out_update);

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task bus(input w, input [8:0] a, input [7:0] wd, input b0);
    begin
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, wd};
      avs_byteenable <= {3'h7, b0};
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk_sys);
      rv = avs_readdata;
      rs = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
    end
  endtask

  task wr(input [6:0] i, input [7:0] wd);
    bus(1'b1, {i, 2'b00}, wd, 1'b1);
  endtask

  task rdchk(input [6:0] i, input [7:0] e);
    begin
      bus(1'b0, {i, 2'b00}, 8'h00, 1'b1);
      check(rv, {24'h0, e});
      check(rs, 2'h0);
    end
  endtask

  // Register value as seen on the analog-side outputs
  function [7:0] out_of(input [6:0] i);
    case (i)
      7'h39: out_of = {rdac_lcom_route, rdac_lcom_vol};
      7'h3A: out_of = {left_com_level, left_com_unmute, left_com_hiz,
                       left_com_pending, left_com_power_up};
      7'h3C: out_of = {lgain_rout_route, lgain_rout_vol};
      7'h3D: out_of = {ldac_rout_route, ldac_rout_vol};
      7'h3F: out_of = {rgain_rout_route, rgain_rout_vol};
      7'h40: out_of = {rdac_rout_route, rdac_rout_vol};
      7'h41: out_of = {right_out_level, right_out_unmute, right_out_hiz,
                       right_out_pending, right_out_power_up};
      default: out_of = 8'h00;
    endcase
  endfunction

  // One-cycle gains-applied pulse from the analog side
  task pulse(input r);
    begin
      if (r) right_out_applied <= 1'b1;
      else left_com_applied <= 1'b1;
      @(posedge clk_sys);
      right_out_applied <= 1'b0;
      left_com_applied <= 1'b0;
      @(posedge clk_sys);
    end
  endtask

  // Reset values of the whole slice, bus and outputs
  task t_reset;
    integer i;
    reg [7:0] e;
    begin
      for (i = 8'h39; i < 8'h42; i = i + 1) begin
        e = (i == 8'h3A || i == 8'h41) ? 8'h06 : 8'h00;
        rdchk(i[6:0], e);
        check(out_of(i[6:0]), e);
      end
    end
  endtask

  // Distinct pattern in every routing register, read back after all
  task t_route;
    integer i;
    begin
      for (i = 8'h39; i < 8'h41; i = i + 1)
        if (i != 8'h3A && i != 8'h3B && i != 8'h3E)
          wr(i[6:0], 8'hC3 ^ i[7:0]);
      for (i = 8'h39; i < 8'h41; i = i + 1)
        if (i != 8'h3A && i != 8'h3B && i != 8'h3E) begin
          rdchk(i[6:0], 8'hC3 ^ i[7:0]);
          check(out_of(i[6:0]), 8'hC3 ^ i[7:0]);
        end
    end
  endtask

  // Control register: top level, refused level, pending set and clear
  task t_ctrl(input [6:0] i, input r);
    begin
      pulse(r);
      rdchk(i, 8'h04);
      wr(i, 8'h9D);
      rdchk(i, 8'h9F);
      check(out_of(i), 8'h9F);
      wr(i, 8'hA0);
      rdchk(i, 8'h92);
      pulse(r);
      rdchk(i, 8'h90);
      wr(i, 8'h00);
      rdchk(i, 8'h02);
    end
  endtask

  // Gain write on one output leaves the other settled
  task t_cross;
    begin
      pulse(1'b0);
      pulse(1'b1);
      wr(7'h3C, 8'h11);
      check(left_com_pending, 1'b0);
      check(right_out_pending, 1'b1);
    end
  endtask

  // Unmapped, unaligned and byte-disabled accesses
  task t_refuse;
    begin
      bus(1'b0, 9'h0E0, 8'h00, 1'b1);
      check(rv, 32'h0);
      check(rs, 2'h2);
      bus(1'b1, 9'h108, 8'h55, 1'b1);
      check(rs, 2'h2);
      bus(1'b0, 9'h0E5, 8'h00, 1'b1);
      check(rs, 2'h2);
      bus(1'b1, {7'h3F, 2'b00}, 8'hEE, 1'b0);
      rdchk(7'h3F, 8'hFC);
    end
  endtask

  // Clock enable low freezes the handshake and the registers
  task t_freeze;
    begin
      ce <= 1'b0;
      avs_address <= {7'h3D, 2'b00};
      avs_writedata <= 32'h0000005A;
      avs_byteenable <= 4'hF;
      avs_write <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check(avs_waitrequest, 1'b1);
      check(out_of(7'h3D), 8'hFE);
      ce <= 1'b1;
      while (avs_waitrequest !== 1'b0)
        @(posedge clk_sys);
      avs_write <= 1'b0;
      @(posedge clk_sys);
      check(out_of(7'h3D), 8'h5A);
    end
  endtask

  task finish_test;
    begin
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // Watchdog against a hung handshake
  initial begin
    #200000;
    miscompares = miscompares + 1;
    finish_test;
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_route;
    t_ctrl(7'h3A, 1'b0);
    t_ctrl(7'h41, 1'b1);
    t_cross;
    t_refuse;
    t_freeze;
    finish_test;
  end
endmodule // hp_routing_regs_tb_top
